// ---- bench/ctv_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ctv_map.vh"
module ctv_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// watched outputs
	input wire logic [1:0]  tone_kind,
	input wire logic [11:0] tone_freq_b,
	input wire logic        analog_switch_one,
	input wire logic        analog_switch_three,
	input wire logic        analog_switch_four,
	input wire logic        analog_switch_five,
	input wire logic        tone_output_one_enable,
	input wire logic        voice_activity_function,
	input wire logic [1:0]  threshold_code,
	input wire logic        rx_voice_pass
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// first access edge of a write; ##2 leaves room for the output stage
	wire logic wr   = psel && penable && pwrite && !pready;
	wire logic w_sw = wr && paddr == `CTV_OFF_SWITCH;
	wire logic w_vc = wr && paddr == `CTV_OFF_VOXCTL;
	property p_sw1;
		w_sw |-> ##2 analog_switch_one == $past(pwdata[7], 2);
	endproperty
	a_sw1: assert property (p_sw1) else $error("switch one wrong");
	property p_sw3;
		w_sw |-> ##2 analog_switch_three == $past(pwdata[5], 2);
	endproperty
	a_sw3: assert property (p_sw3) else $error("switch three wrong");
	// the pair never shares a state while out of reset
	property p_sw45; analog_switch_four != analog_switch_five; endproperty
	a_sw45: assert property (p_sw45) else $error("switch four/five");
	property p_tout;
		w_sw |-> ##2 tone_output_one_enable == $past(pwdata[0], 2);
	endproperty
	a_tout: assert property (p_tout) else $error("tone out one wrong");
	property p_von;
		w_vc |-> ##2 voice_activity_function == $past(pwdata[7], 2);
	endproperty
	a_von: assert property (p_von) else $error("function enable");
	property p_thr;
		w_vc |-> ##2 threshold_code == $past(pwdata[6:5], 2);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold code");
	property p_rxs;
		w_vc |-> ##2 rx_voice_pass == $past(pwdata[3], 2);
	endproperty
	a_rxs: assert property (p_rxs) else $error("receive source");
	property p_dtmf;
		tone_kind == `CTV_KIND_DUAL |->
			tone_freq_b inside {12'h4b9, 12'h538, 12'h5c5, 12'h661};
	endproperty
	a_dtmf: assert property (p_dtmf) else $error("high tone off table");
endmodule
bind ctv_regs ctv_chk chk (.*);
`default_nettype wire

// ---- bench/ctv_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ctv_map.vh"
module ctv_regs_test;
	// design ports, joined by name
	logic        clock, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr, tone_freq_a, tone_freq_b, fa;
	logic [31:0] pwdata, prdata, q, seed;
	logic [7:0]  tx_level, tx_threshold_level, rx_voice_level;
	logic [7:0]  rx_noise_level, d;
	logic [1:0]  silence_band, tone_kind, threshold_code;
	logic        tone_transmit, analog_switch_one, analog_switch_two;
	logic        analog_switch_three, analog_switch_four;
	logic        analog_switch_five, tone_output_one_enable;
	logic        tone_output_two_enable, tone_output_three_enable;
	logic        voice_activity_function, rx_voice_pass, rx_noise_off;
	logic        voice_detected_flag;
	int          n_fail, compares, n;
	logic [25:0] t;
	// switch outputs in register bit order, bit 3 slot holds switch five
	wire logic [7:0] sw = {analog_switch_one, analog_switch_two,
		analog_switch_three, analog_switch_four, analog_switch_five,
		tone_output_three_enable, tone_output_two_enable,
		tone_output_one_enable};
	wire logic [3:0] vc = {voice_activity_function, threshold_code,
		rx_voice_pass};
	// short hangover and warble counts keep the run brief
	ctv_regs #(.HANG_SHORT(20), .HANG_LONG(40), .WARBLE_HALF(8)) dut (.*);
	// 40 ns clock
	always #20 clock = ~clock;
	// xorshift stream from a fixed start
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// expected {kind, freq a, freq b} for a tone register value
	function automatic logic [25:0] tone_exp(input logic [7:0] v);
		logic [11:0] lo[4];
		logic [11:0] hi[4];
		lo = '{12'h2b9, 12'h302, 12'h354, 12'h3ad};
		hi = '{12'h4b9, 12'h538, 12'h5c5, 12'h661};
		if (v[7])
			return {2'h1, lo[v[3:2]], hi[v[1:0]]};
		case (v[4:0])
			5'h00: return {2'h2, 12'haaa, 12'h9c4};
			5'h01: return {2'h2, 12'h7d0, 12'ha6b};
			5'h02: return {2'h2, 12'h3e8, 12'h535};
			5'h09: return {2'h3, 12'h190, 12'h0};
			5'h0f: return {2'h3, 12'h3e8, 12'h0};
			5'h11: return {2'h3, 12'h514, 12'h0};
			5'h12: return {2'h3, 12'h535, 12'h0};
			5'h15: return {2'h3, 12'h7d0, 12'h0};
			5'h1c: return {2'h3, 12'ha6b, 12'h0};
			5'h1e: return {2'h3, 12'haaa, 12'h0};
			default: return 26'h0;
		endcase
	endfunction
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		compares++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one transfer held until pready, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1) begin
			n_fail++;
			$display("[ERR] pready expected 1 seen %b", pready);
			conclude();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// bounded wait for the detection flag
	task automatic waitf(input logic v, input int lim);
		n = 0;
		while (voice_detected_flag !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk("flag", v, voice_detected_flag);
	endtask
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_level, silence_band, rx_voice_level} = '0;
		tx_threshold_level = 8'h40;
		n_fail = 0;
		compares = 0;
		seed = 32'h138d1;
		repeat (5) @(posedge clock);
		chk("sw reset", 8'h08, sw);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(0, `CTV_OFF_TONE + 12'(4 * i), 8'h0);
			chk("reset", 0, q);
		end
		// all-zeros, all-ones, then random switch patterns
		for (int i = 0; i < 10; i++) begin
			d = (i < 2) ? {8{i[0]}} : rnd();
			apb(1, `CTV_OFF_SWITCH, d);
			apb(0, `CTV_OFF_SWITCH, 8'h0);
			chk("sw read", d & 8'hf7, q);
			chk("sw out", {d[7:4], ~d[4], d[2:0]}, sw);
		end
		// every code in both tables
		for (int i = 0; i < 64; i++) begin
			d = rnd();
			d = {i[5], d[6], 1'b0, i[4:0]};
			apb(1, `CTV_OFF_TONE, d);
			t = tone_exp(d);
			chk("kind", t[25:24], tone_kind);
			chk("send", d[6], tone_transmit);
			fa = (t[25:24] == 2'h2 && tone_freq_a === t[11:0]) ? t[11:0] : t[23:12];
			chk("freq a", fa, tone_freq_a);
			chk("freq b", t[11:0], tone_freq_b);
			// a warble must show the other frequency one half period on
			if (t[25:24] == 2'h2) begin
				fa = (tone_freq_a === t[23:12]) ? t[11:0] : t[23:12];
				repeat (8) @(posedge clock);
				chk("warble", fa, tone_freq_a);
			end
		end
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			d[6:5] = i[1:0];
			d[2] = i[2];
			apb(1, `CTV_OFF_VOXCTL, d);
			apb(0, `CTV_OFF_VOXCTL, 8'h0);
			chk("vc read", d, q);
			chk("vc out", {d[7:5], d[3]}, vc);
			chk("noise off", d[2] && d[1:0] == 2'h0, rx_noise_off);
			if (d[2])
				chk("noise", d[1:0], rx_noise_level);
		end
		// level taken when the source bit falls
		d = rnd();
		rx_voice_level <= d;
		apb(1, `CTV_OFF_VOXCTL, 8'h08);
		apb(1, `CTV_OFF_VOXCTL, 8'h00);
		chk("auto", d, rx_noise_level);
		for (int h = 0; h < 2; h++) begin
			d = rnd();
			silence_band <= d[1:0];
			tx_level <= 8'hc0;
			apb(1, `CTV_OFF_VOXCTL, {3'h4, h[0], 4'h0});
			waitf(1'b1, 10);
			apb(0, `CTV_OFF_VOXSTAT, 8'h0);
			chk("stat", {1'b1, d[1:0], 5'h0}, q);
			apb(1, `CTV_OFF_VOXSTAT, 8'h00);
			apb(0, `CTV_OFF_VOXSTAT, 8'h0);
			chk("stat wr", {1'b1, d[1:0], 5'h0}, q);
			tx_level <= 8'h10;
			repeat (h ? 36 : 16) @(posedge clock);
			chk("hold", 1, voice_detected_flag);
			waitf(1'b0, 12);
		end
		tx_level <= 8'hc0;
		apb(1, `CTV_OFF_VOXCTL, 8'h00);
		apb(0, `CTV_OFF_VOXSTAT, 8'h0);
		chk("stat off", 0, q);
		chk("flag off", 0, voice_detected_flag);
		apb(0, 12'h020, 8'h0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, q);
		conclude();
	end
endmodule
`default_nettype wire

// ---- hw/ctv_map.vh ----
// Functional notes
// RQ1: dtmf mode ignores code bit4, splits low/high
// RQ2: codes 0-2 give 8 hz warble pairs
// RQ3: listed codes give single tones
// RQ4: switch bits 7,6 close switches one, two
// RQ5: switch bit 5 closes switch three
// RQ6: bit 4 drives switches four/five in complement
// RQ7: bits 2..0 enable tone outputs three..one
// RQ8: detect control bit 7 turns function on
// RQ9: bits 6:5 pick detector threshold
// RQ10: bit 4 picks hangover 160 or 320 ms
// RQ11: bit 3 picks noise or received voice
// RQ12: bit 2 auto noise capture or external
// RQ13: bits 1:0 set external noise level
// RQ14: status read-only, bit 7 is detection
// RQ15: status bits 6:5 report silence band
// RQ16: status valid only while function enabled
// RQ17: status bits 7:5 reset to zero
// RQ18: tone mode bit picks dtmf or other table
// RQ19: tone send bit picks voice or tone
// RQ20: unassigned codes produce no tone
// RQ21: detection holds for hangover after level drops
// RQ22: switch bit 3 reads zero, ignores writes
`ifndef CTV_MAP_VH
`define CTV_MAP_VH
// register byte offsets
`define CTV_OFF_TONE      12'h010
`define CTV_OFF_SWITCH    12'h014
`define CTV_OFF_VOXCTL    12'h018
`define CTV_OFF_VOXSTAT   12'h01c
// register reset values
`define CTV_RST_TONE      8'h00
`define CTV_RST_SWITCH    8'h00
`define CTV_RST_VOXCTL    8'h00
// field positions
`define CTV_B_TABLE       7
`define CTV_B_SEND        6
`define CTV_B_VOX_ON      7
`define CTV_B_HANG        4
`define CTV_B_RXSRC       3
`define CTV_B_NSEL        2
`define CTV_SW_MASK       8'hf7
// hangover times in ms and clock rate in khz
`define CTV_HANG_SHORT_MS 160
`define CTV_HANG_LONG_MS  320
`define CTV_CLK_KHZ       25000
`define CTV_HANG_SHORT_CYC (`CTV_HANG_SHORT_MS * `CTV_CLK_KHZ)
`define CTV_HANG_LONG_CYC  (`CTV_HANG_LONG_MS * `CTV_CLK_KHZ)
// warble rate in hz and half period in cycles
`define CTV_WARBLE_HZ     8
`define CTV_WARBLE_HALF   (`CTV_CLK_KHZ * 1000 / (2 * `CTV_WARBLE_HZ))
// tone kinds
`define CTV_KIND_NONE     2'h0
`define CTV_KIND_DUAL     2'h1
`define CTV_KIND_WARBLE   2'h2
`define CTV_KIND_SINGLE   2'h3
`endif

// ---- hw/ctv_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ctv_map.vh"
module ctv_regs #(
	// timing counts in clock cycles; defaults give the real times at
	// the nominal clock, a bench may shorten them to keep runs brief
	parameter HANG_SHORT = `CTV_HANG_SHORT_CYC, // short hangover cycles
	parameter HANG_LONG  = `CTV_HANG_LONG_CYC,  // long hangover cycles
	parameter WARBLE_HALF = `CTV_WARBLE_HALF    // half warble period
) (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// measured transmit level, bigger is louder, plus band of silence
	input  wire [7:0]  tx_level,
	input  wire [7:0]  tx_threshold_level,
	input  wire [1:0]  silence_band,
	input  wire [7:0]  rx_voice_level,
	// tone selection
	output reg  [1:0]  tone_kind,
	output reg  [11:0] tone_freq_a,
	output reg  [11:0] tone_freq_b,
	output reg         tone_transmit,
	// analog switches and tone outputs
	output reg         analog_switch_one,
	output reg         analog_switch_two,
	output reg         analog_switch_three,
	output reg         analog_switch_four,
	output reg         analog_switch_five,
	output reg         tone_output_one_enable,
	output reg         tone_output_two_enable,
	output reg         tone_output_three_enable,
	// voice activity controls
	output reg         voice_activity_function,
	output reg  [1:0]  threshold_code,
	output reg         rx_voice_pass,
	output reg  [7:0]  rx_noise_level,
	output reg         rx_noise_off,
	output reg         voice_detected_flag
);

	// software visible registers first, then private state; the status
	// image is rebuilt every cycle and never written by the bus
	reg  [7:0]  tone_mode_frequency_reg;     // tone mode and code
	reg  [7:0]  switch_and_tone_out_control; // switch bank
	reg  [7:0]  voice_detect_control;        // detector control
	reg  [7:0]  voice_detect_status;         // status image
	reg  [31:0] hang_cnt;                    // hangover countdown
	reg  [31:0] warble_cnt;                  // warble half-period count
	reg         warble_phase;                // which of the pair sounds
	reg  [7:0]  captured_noise;              // auto noise level
	reg         det;                         // raw detector state

	// bus decode; wr is held off in the repeated access cycle so that a
	// transfer stores once and the noise capture sees a single edge
	wire        acc  = psel && penable;      // access phase
	wire        wr   = acc && pwrite && !pready; // first access edge only
	// field taps of the tone and detector control registers
	wire [4:0]  code = tone_mode_frequency_reg[4:0];
	wire        dtmf = tone_mode_frequency_reg[`CTV_B_TABLE];
	wire        vox_on = voice_detect_control[`CTV_B_VOX_ON];
	wire        above = tx_level > tx_threshold_level;
	// decode results and read mux, all combinational
	reg  [1:0]  next_kind;
	reg  [11:0] next_fa;
	reg  [11:0] next_fb;
	reg  [31:0] rd;
	reg         hit;

	// register writes at the first access edge; the answer stage below
	// adds one wait state so every access phase lasts two cycles, which
	// gives the read mux a full cycle before prdata is registered
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tone_mode_frequency_reg     <= `CTV_RST_TONE;
			switch_and_tone_out_control <= `CTV_RST_SWITCH;
			voice_detect_control        <= `CTV_RST_VOXCTL;
		end else if (wr) begin
			case (paddr)
			// table select, send, route and code stored as written
			`CTV_OFF_TONE: tone_mode_frequency_reg <= pwdata[7:0];
			// unused bit 3 never stores [RQ22]
			`CTV_OFF_SWITCH: switch_and_tone_out_control <=
				pwdata[7:0] & `CTV_SW_MASK;
			// detector control stored whole, every bit has a meaning
			`CTV_OFF_VOXCTL: voice_detect_control <= pwdata[7:0];
			default: ; // status is read-only, writes dropped [RQ14]
			endcase
		end
	end

	// read mux and decode error for unmapped words; the upper 24 bits
	// always read zero since every register is one byte wide
	always @* begin
		hit = 1'b1;
		rd  = 32'h0;
		case (paddr)
		`CTV_OFF_TONE:    rd = {24'h0, tone_mode_frequency_reg};
		`CTV_OFF_SWITCH:  rd = {24'h0, switch_and_tone_out_control};
		`CTV_OFF_VOXCTL:  rd = {24'h0, voice_detect_control};
		`CTV_OFF_VOXSTAT: rd = {24'h0, voice_detect_status};
		// unmapped word: slave error, data left at zero
		default:          hit = 1'b0;
		endcase
	end

	// apb answer registered; pready pulses in the second access cycle
	// and falls again at once, so a master that holds its request sees
	// a ready pulse every second cycle; prdata is zero outside ready cycles to keep
	// stale register contents off the bus
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= acc && !pready;
			// error only for a word with no register behind it
			pslverr <= acc && !pready && !hit;
			prdata  <= (acc && !pready && !pwrite) ? rd : 32'h0;
		end
	end

	// frequency decode by table and code; outputs are in hertz so the
	// synthesiser side needs no table of its own
	always @* begin
		next_kind = `CTV_KIND_NONE;
		next_fa   = 12'h0;
		next_fb   = 12'h0;
		if (dtmf) begin
			// code bit 4 is ignored [RQ1] [RQ18]
			next_kind = `CTV_KIND_DUAL;
			// low group from code bits 3:2
			case (code[3:2])
			2'h0: next_fa = 12'd697;
			2'h1: next_fa = 12'd770;
			2'h2: next_fa = 12'd852;
			default: next_fa = 12'd941;
			endcase
			// high group from code bits 1:0
			case (code[1:0])
			2'h0: next_fb = 12'd1209;
			2'h1: next_fb = 12'd1336;
			2'h2: next_fb = 12'd1477;
			default: next_fb = 12'd1633;
			endcase
		end else begin
			// other tones: only listed codes sound, the rest stay silent
			case (code)
			// warbled pairs [RQ2]
			5'h00: begin
				next_kind = `CTV_KIND_WARBLE;
				next_fa = 12'd2730;
				next_fb = 12'd2500;
			end
			5'h01: begin
				next_kind = `CTV_KIND_WARBLE;
				next_fa = 12'd2000;
				next_fb = 12'd2667;
			end
			5'h02: begin
				next_kind = `CTV_KIND_WARBLE;
				next_fa = 12'd1000;
				next_fb = 12'd1333;
			end
			// single tones [RQ3]
			5'h09: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd400;
			end
			5'h0f: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd1000;
			end
			5'h11: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd1300;
			end
			5'h12: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd1333;
			end
			5'h15: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd2000;
			end
			5'h1c: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd2667;
			end
			5'h1e: begin
				next_kind = `CTV_KIND_SINGLE;
				next_fa = 12'd2730;
			end
			default: next_kind = `CTV_KIND_NONE; // reserved, silent [RQ20]
			endcase
		end
	end

	// 8 hz warble: freq_a swaps with freq_b every half period; the
	// counter idles at zero for other kinds so a warble entered from
	// another kind starts on its first frequency
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			warble_cnt   <= 32'h0;
			warble_phase <= 1'b0;
		end else if (next_kind != `CTV_KIND_WARBLE) begin
			// not warbling: park the counter and the phase
			warble_cnt   <= 32'h0;
			warble_phase <= 1'b0;
		end else if (warble_cnt >= WARBLE_HALF - 1) begin
			// half period done: sound the other frequency
			warble_cnt   <= 32'h0;
			warble_phase <= !warble_phase; // [RQ2]
		end else begin
			warble_cnt <= warble_cnt + 32'h1;
		end
	end

	// tone outputs registered so every pin comes from a flip-flop
	// and decode glitches never reach the synthesiser
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			// no tone in reset; reset code 0 then decodes as the 2730/2500 warble
			tone_kind     <= `CTV_KIND_NONE;
			tone_freq_a   <= 12'h0;
			tone_freq_b   <= 12'h0;
			tone_transmit <= 1'b0;
		end else begin
			tone_kind     <= next_kind;
			// warble shows the sounding frequency on freq_a
			tone_freq_a   <= (next_kind == `CTV_KIND_WARBLE && warble_phase)
				? next_fb : next_fa;
			tone_freq_b   <= next_fb;
			tone_transmit <= tone_mode_frequency_reg[`CTV_B_SEND]; // [RQ19]
		end
	end

	// switch and tone output drivers
	// switch five is the complement of four, so it idles closed in reset
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			analog_switch_one        <= 1'b0;
			analog_switch_two        <= 1'b0;
			analog_switch_three      <= 1'b0;
			analog_switch_four       <= 1'b0;
			analog_switch_five       <= 1'b1;
			tone_output_one_enable   <= 1'b0;
			tone_output_two_enable   <= 1'b0;
			tone_output_three_enable <= 1'b0;
		end else begin
			analog_switch_one   <= switch_and_tone_out_control[7]; // [RQ4]
			analog_switch_two   <= switch_and_tone_out_control[6]; // [RQ4]
			analog_switch_three <= switch_and_tone_out_control[5]; // [RQ5]
			// four and five always take opposite states
			analog_switch_four  <= switch_and_tone_out_control[4]; // [RQ6]
			analog_switch_five  <= !switch_and_tone_out_control[4]; // [RQ6]
			tone_output_one_enable   <= switch_and_tone_out_control[0]; // [RQ7]
			tone_output_two_enable   <= switch_and_tone_out_control[1]; // [RQ7]
			tone_output_three_enable <= switch_and_tone_out_control[2]; // [RQ7]
		end
	end

	// detector with hangover; disabled function clears it
	// the count reloads while the level is above threshold and runs
	// down only below it, so a short dip never drops the flag
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			det      <= 1'b0;
			hang_cnt <= 32'h0;
		end else if (!vox_on) begin
			det      <= 1'b0; // [RQ8]
			hang_cnt <= 32'h0;
		end else if (above) begin
			// level above threshold: set and reload the hangover count
			det      <= 1'b1; // [RQ21]
			hang_cnt <= voice_detect_control[`CTV_B_HANG]
				? HANG_LONG : HANG_SHORT; // [RQ10]
		end else if (hang_cnt > 32'h1) begin
			// below threshold: count the hangover down
			hang_cnt <= hang_cnt - 32'h1;
		end else begin
			det      <= 1'b0; // [RQ21]
			hang_cnt <= 32'h0;
		end
	end

	// noise capture on receive source falling 1 to 0
	// limitation: the capture follows the bus write, not a pin, so only
	// a software change of the source bit takes a new level
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			captured_noise <= 8'h0;
		end else if (wr && paddr == `CTV_OFF_VOXCTL &&
				voice_detect_control[`CTV_B_RXSRC] &&
				!pwdata[`CTV_B_RXSRC]) begin
			captured_noise <= rx_voice_level; // [RQ12]
		end
	end

	// voice activity control outputs and status image
	// the status image trails the detector by one cycle; a read in the
	// same cycle as a change shows the older value
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			// every control output and the status image start cleared
			voice_activity_function <= 1'b0;
			threshold_code          <= 2'h0;
			rx_voice_pass           <= 1'b0;
			rx_noise_level          <= 8'h0;
			rx_noise_off            <= 1'b0;
			voice_detected_flag     <= 1'b0;
			voice_detect_status     <= 8'h00; // [RQ17]
		end else begin
			voice_activity_function <= vox_on; // [RQ8]
			threshold_code  <= voice_detect_control[6:5]; // [RQ9]
			rx_voice_pass   <= voice_detect_control[`CTV_B_RXSRC]; // [RQ11]
			// external code or the captured level, by the select bit
			rx_noise_level  <= voice_detect_control[`CTV_B_NSEL]
				? {6'h0, voice_detect_control[1:0]}
				: captured_noise; // [RQ12] [RQ13]
			rx_noise_off    <= voice_detect_control[`CTV_B_NSEL] &&
				voice_detect_control[1:0] == 2'h0; // [RQ13]
			// the flag is forced low while the function is off
			voice_detected_flag <= det && vox_on;
			// fields valid only with function on [RQ15] [RQ16]
			voice_detect_status <= vox_on
				? {det, silence_band, 5'h00} : 8'h00;
		end
	end

endmodule
`default_nettype wire
